/* File: design/oag_consts.vh */
// constants for the operand address generator
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH
// address modes
`define OAG_MODE_W 3
`define OAG_MODE_DIRECT 3'h0
`define OAG_MODE_SHORT 3'h1
`define OAG_MODE_SPECIAL 3'h2
`define OAG_MODE_INDIRECT 3'h3
`define OAG_MODE_BASED 3'h4
`define OAG_MODE_STACK 3'h5
`define OAG_MODE_REG 3'h6
// pair codes
`define OAG_PAIR_IDX 2'h2
`define OAG_PAIR_BASE 2'h3
// byte register numbers x a c b e d l h
`define OAG_REG_A 3'h1
`define OAG_REG_E 3'h4
`define OAG_REG_D 3'h5
`define OAG_REG_L 3'h6
`define OAG_REG_H 3'h7
// short direct window
`define OAG_SHORT_HI 7'h7f
`define OAG_SHORT_LIMIT 8'h20
// special register page high byte
`define OAG_SPECIAL_HI 8'hff
`define OAG_SPECIAL_MIN 8'h20
// accumulator load through index pair
`define OAG_OP_LD_A_IDX 8'h2b
`endif

/* File: design/oag_regfile.v */
// eight byte registers with one registered read port; pair outputs come straight from the registers
`timescale 1ns/1ps
`include "oag_consts.vh"
module oag_regfile (
  input wire clk_i,
  input wire rst_n_i,
  input wire wr_en_i,
  input wire [2:0] wr_sel_i,
  input wire [7:0] wr_data_i,
  input wire [2:0] rd_sel_i,
  output reg [7:0] rd_data_o,
  output wire [15:0] idx_pair_o,
  output wire [15:0] base_pair_o
);
  reg [7:0] mem_q [0:7];
  integer i;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
      rd_data_o <= 8'h00;
    end else begin
      if (wr_en_i) begin
        mem_q[wr_sel_i] <= wr_data_i;
      end
      rd_data_o <= mem_q[rd_sel_i];
    end
  end
  // pairs join adjacent bytes, odd number is the high byte
  assign idx_pair_o = {mem_q[`OAG_REG_D], mem_q[`OAG_REG_E]};
  assign base_pair_o = {mem_q[`OAG_REG_H], mem_q[`OAG_REG_L]};
endmodule // oag_regfile

/* File: design/oag_addr_gen.v */
// operand effective address generator for an 8-bit core
`timescale 1ns/1ps
`include "oag_consts.vh"
// What this block does
// - short direct: bit 8 is 0 for 20h..ffh, 1 for 00h..1fh
// - short direct window fe20h..ff1fh, bit 8 alpha, upper bits ones
// - special register form picks one byte of ff20h..ffffh; offsets below 20h are refused
// - ff00h..ff1fh reached by short direct, not special form
// - 3-bit opcode field selects one of eight byte registers
// - registers numbered x a c b e d l h; pairs of adjacent bytes
// - register indirect uses index or base pair as full address
// - opcode 2bh loads accumulator through index pair
// - based: zero-extended offset plus base pair, carry dropped
// - stack operations address through the stack pointer
module oag_addr_gen (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire req_i,
  input wire [2:0] mode_i,
  input wire [7:0] opcode_i,
  input wire [7:0] imm_lo_i,
  input wire [7:0] imm_hi_i,
  input wire [2:0] reg_sel_i,
  input wire [1:0] pair_sel_i,
  input wire [15:0] stack_pointer_i,
  input wire reg_wr_i,
  input wire [2:0] reg_wr_sel_i,
  input wire [7:0] reg_wr_data_i,
  output reg addr_valid_o,
  output reg [15:0] addr_o,
  output reg bad_mode_o,
  output reg load_acc_o,
  output reg reg_valid_o,
  output reg [2:0] reg_num_o,
  output wire [7:0] reg_data_o
);
  // ===========================================================
  // reset release
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ===========================================================
  // byte registers
  wire [15:0] idx_pair;
  wire [15:0] base_pair;
  wire [2:0] rd_sel;
  // the fixed indirect opcode overrides the mode field
  wire is_ld_idx = (opcode_i == `OAG_OP_LD_A_IDX);
  // register field is a 3-bit code straight from the opcode
  assign rd_sel = is_ld_idx ? `OAG_REG_A : reg_sel_i;
  oag_regfile u_regs (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_sync_q),
    .wr_en_i(reg_wr_i),
    .wr_sel_i(reg_wr_sel_i),
    .wr_data_i(reg_wr_data_i),
    .rd_sel_i(rd_sel),
    .rd_data_o(reg_data_o),
    .idx_pair_o(idx_pair),
    .base_pair_o(base_pair)
  );

  // ===========================================================
  // address forming
  reg [15:0] addr_d;
  reg valid_d;
  reg bad_d;
  reg [15:0] ptr;
  always @* begin
    addr_d = 16'h0000;
    valid_d = 1'b0;
    bad_d = 1'b0;
    // only the two pointer pairs may serve as indirect pointers
    ptr = (pair_sel_i == `OAG_PAIR_IDX) ? idx_pair : base_pair;
    if (req_i) begin
      if (is_ld_idx) begin
        addr_d = idx_pair;
        valid_d = 1'b1;
      end else begin
        case (mode_i)
          `OAG_MODE_DIRECT: begin
            addr_d = {imm_hi_i, imm_lo_i};
            valid_d = 1'b1;
          end
          `OAG_MODE_SHORT: begin
            // alpha lands in bit 8; 00h..1fh wrap to ff00h..ff1fh
            addr_d = {`OAG_SHORT_HI,
              (imm_lo_i < `OAG_SHORT_LIMIT), imm_lo_i};
            valid_d = 1'b1;
          end
          `OAG_MODE_SPECIAL: begin
            // low 32 bytes belong to the short form; flagged here
            if (imm_lo_i < `OAG_SPECIAL_MIN) begin
              bad_d = 1'b1;
            end else begin
              addr_d = {`OAG_SPECIAL_HI, imm_lo_i};
              valid_d = 1'b1;
            end
          end
          `OAG_MODE_INDIRECT: begin
            if (pair_sel_i == `OAG_PAIR_IDX ||
                pair_sel_i == `OAG_PAIR_BASE) begin
              addr_d = ptr;
              valid_d = 1'b1;
            end else begin
              bad_d = 1'b1;
            end
          end
          `OAG_MODE_BASED: begin
            // 16-bit sum drops the carry, so the address wraps
            addr_d = base_pair + {8'h00, imm_lo_i};
            valid_d = 1'b1;
          end
          `OAG_MODE_STACK: begin
            // no range check: keeping it in ram is software's job
            addr_d = stack_pointer_i;
            valid_d = 1'b1;
          end
          `OAG_MODE_REG: begin
            valid_d = 1'b0;
          end
          default: begin
            bad_d = 1'b1;
          end
        endcase
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      addr_valid_o <= 1'b0;
      addr_o <= 16'h0000;
      bad_mode_o <= 1'b0;
      load_acc_o <= 1'b0;
      reg_valid_o <= 1'b0;
      reg_num_o <= 3'h0;
    end else begin
      addr_valid_o <= valid_d;
      addr_o <= addr_d;
      bad_mode_o <= bad_d;
      load_acc_o <= req_i & is_ld_idx;
      reg_valid_o <= req_i & (is_ld_idx | (mode_i == `OAG_MODE_REG));
      reg_num_o <= rd_sel;
    end
  end
endmodule // oag_addr_gen

/* File: dv/oag_addr_gen_properties.sv */
// port assertions for the operand address generator
`timescale 1ns/1ps
module oag_addr_gen_properties (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire req_i,
  input wire [2:0] mode_i,
  input wire [7:0] opcode_i,
  input wire [7:0] imm_lo_i,
  input wire [1:0] pair_sel_i,
  input wire [2:0] reg_sel_i,
  input wire [15:0] stack_pointer_i,
  input wire addr_valid_o,
  input wire [15:0] addr_o,
  input wire bad_mode_o,
  input wire load_acc_o,
  input wire reg_valid_o,
  input wire [2:0] reg_num_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // opcode 2bh overrides the mode field
  wire go_plain = req_i && opcode_i != 8'h2b;
  chk_short_win: assert property (go_plain && mode_i == 3'h1 |=>
    addr_valid_o && addr_o == {7'h7f, $past(imm_lo_i) < 8'h20,
    $past(imm_lo_i)}) else $error("short address wrong");
  chk_special_page: assert property (go_plain && mode_i == 3'h2 &&
    imm_lo_i >= 8'h20 |=> addr_valid_o && addr_o == {8'hff,
    $past(imm_lo_i)}) else $error("special address wrong");
  chk_special_low: assert property (go_plain && mode_i == 3'h2 &&
    imm_lo_i < 8'h20 |=> bad_mode_o && !addr_valid_o)
    else $error("low special not refused");
  chk_reg_pick: assert property (go_plain && mode_i == 3'h6 |=>
    reg_valid_o && reg_num_o == $past(reg_sel_i)) else $error("reg pick");
  chk_acc_load: assert property (req_i && opcode_i == 8'h2b |=>
    load_acc_o && reg_valid_o && reg_num_o == 3'h1) else $error("acc load");
  chk_stack_addr: assert property (go_plain && mode_i == 3'h5 |=>
    addr_valid_o && addr_o == $past(stack_pointer_i)) else $error("stack");
  chk_pair_bad: assert property (go_plain && mode_i == 3'h3 &&
    !pair_sel_i[1] |=> bad_mode_o && !addr_valid_o) else $error("pair");
  chk_idle_quiet: assert property (!req_i |=>
    !addr_valid_o && !bad_mode_o && !load_acc_o) else $error("idle out");
  cover property (go_plain && mode_i == 3'h4);
  cover property (req_i && opcode_i == 8'h2b);
  cover property (bad_mode_o ##1 addr_valid_o);
endmodule // oag_addr_gen_properties

/* File: dv/oag_dec_model.sv */
// decoder side model: supplies the stack pointer
`timescale 1ns/1ps
module oag_dec_model (
  input wire clk_i,
  output logic [15:0] sp_o = 16'hfe20
);
  // software keeps the pointer inside high-speed ram
  always @(posedge clk_i)
    sp_o <= 16'hfe20 + 16'($urandom_range(0, 223));
endmodule // oag_dec_model

/* File: dv/oag_addr_gen_tb.sv */
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module oag_addr_gen_tb;
  logic clk = 0, rst_n = 0, req = 0, wr = 0, av, bm;
  logic [2:0] mode = 0, rsel = 0, wsel = 0;
  logic [7:0] op = 0, lo = 0, hi = 0, wd = 0;
  logic [7:0] r [8];
  logic [1:0] ps = 0;
  logic [15:0] sp, addr;
  logic [16:0] ex;
  logic [16:0] q [$];
  logic rv;
  logic [2:0] rnum;
  logic [7:0] rdat;
  logic [10:0] rex;
  logic [10:0] rq [$];
  int bad_count = 0, n_checks = 0, cyc = 0;
  oag_dec_model i_dec (.clk_i(clk), .sp_o(sp));
  oag_addr_gen i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .req_i(req),
    .mode_i(mode), .opcode_i(op), .imm_lo_i(lo), .imm_hi_i(hi),
    .reg_sel_i(rsel), .pair_sel_i(ps), .stack_pointer_i(sp),
    .reg_wr_i(wr), .reg_wr_sel_i(wsel), .reg_wr_data_i(wd),
    .addr_valid_o(av), .addr_o(addr), .bad_mode_o(bm), .load_acc_o(),
    .reg_valid_o(rv), .reg_num_o(rnum), .reg_data_o(rdat));
  initial forever #2.5 clk = ~clk;
  task automatic final_report;
    if (bad_count == 0 && n_checks > 0 && q.size() == 0 && rq.size() == 0)
      $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic go(input logic [2:0] m, input logic [7:0] o, v);
    logic [16:0] e;
    @(posedge clk);
    req <= 1;
    mode <= m;
    op <= o;
    lo <= v;
    ps <= 2'($urandom);
    hi <= 8'($urandom);
    rsel <= 3'($urandom);
    @(negedge clk);
    if (o == 8'h2b) rq.push_back({3'h1, r[1]});
    else if (m == 3'h6) rq.push_back({rsel, r[rsel]});
    case (o == 8'h2b ? 4'h8 : {1'b0, m})
      0: e = {1'b0, hi, v};
      1: e = {1'b0, 7'h7f, v < 8'h20, v};
      2: e = v < 8'h20 ? 17'h10000 : {9'h0ff, v};
      3: e = ps[1] ? {1'b0, r[{1'b1, ps[0], 1'b1}], r[{1'b1, ps[0], 1'b0}]}
        : 17'h10000;
      4: e = {1'b0, {r[7], r[6]} + {8'h0, v}};
      5: e = {1'b0, sp};
      6: return;
      8: e = {1'b0, r[5], r[4]};
      default: e = 17'h10000;
    endcase
    q.push_back(e);
  endtask
  always @(negedge clk) begin
    if (av !== 1'b0 || bm !== 1'b0) begin
      ex = (q.size() > 0) ? q.pop_front() : 17'h1ffff;
      n_checks++;
      if ({bm, av ? addr : 16'h0} !== ex) begin
        bad_count++;
        $display("MISMATCH %0t got %h exp %h", $time, {bm, addr}, ex);
      end
    end
    if (rv !== 1'b0) begin
      rex = (rq.size() > 0) ? rq.pop_front() : 11'h7ff;
      n_checks++;
      if ({rnum, rdat} !== rex) begin
        bad_count++;
        $display("MISMATCH %0t got %h exp %h", $time, {rnum, rdat}, rex);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    void'($urandom(32'h1f9bd4d3));
    for (int i = 0; i < 8; i++) r[i] = 8'($urandom);
    // high base byte lets the based sum wrap when the low byte plus offset carries
    r[7] = 8'hff;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      wr <= 1;
      wsel <= 3'(i);
      wd <= r[i];
    end
    @(posedge clk);
    wr <= 0;
    for (int i = 0; i < 300; i++)
      go(3'($urandom_range(0, 7)), i % 7 ? 8'h00 : 8'h2b,
        i % 3 ? 8'($urandom) : 8'h1e + 8'(i % 4));
    @(posedge clk);
    req <= 0;
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule // oag_addr_gen_tb
bind oag_addr_gen oag_addr_gen_properties i_chk (.*);
